/* File: inc/pfsel_pkg.sv */
/*
 pfsel_pkg: register indices, field positions, masks and reset values for the
 pin function selection block of ports D, E and F plus the input-route selectors.
 Assumes a 32-bit AHB-Lite slave decoding haddr[7:2] as the word index.
*/
`default_nettype none
package pfsel_pkg;
   // word indices; byte address is four times the index
   localparam logic [5:0] IDX_SEL_FIRST  = 6'h00;  // ten selection regs 0x00..0x09
   localparam logic [5:0] IDX_SEL_LAST   = 6'h09;
   localparam logic [5:0] IDX_DATA_FIRST = 6'h0A;  // port D, E, F data 0x0A..0x0C
   localparam logic [5:0] IDX_DATA_LAST  = 6'h0C;
   localparam logic [5:0] IDX_CTRL_FIRST = 6'h0D;  // port D, E, F direction 0x0D..0x0F
   localparam logic [5:0] IDX_CTRL_LAST  = 6'h0F;
   localparam logic [5:0] IDX_WAKE_EN    = 6'h10;
   localparam logic [5:0] IDX_BIT_OP     = 6'h11;
   localparam logic [5:0] IDX_PORTA_PINS = 6'h12;

   // order of the ten selection registers
   localparam int SEL_D_LOW  = 0;
   localparam int SEL_D_HIGH = 1;
   localparam int SEL_E_LOW  = 2;
   localparam int SEL_E_HIGH = 3;
   localparam int SEL_F_LOW  = 4;
   localparam int SEL_F_HIGH = 5;
   localparam int ROUTE_CLK  = 6;
   localparam int ROUTE_CAP  = 7;
   localparam int ROUTE_SER  = 8;
   localparam int ROUTE_RX   = 9;

   // implemented bits of each selection register, index order as above
   localparam logic [9:0][7:0] SEL_MASK = {8'h03, 8'h7F, 8'h67, 8'h67, 8'hF0,
                                           8'hFF, 8'h03, 8'hFF, 8'h3F, 8'h3F};
   // implemented pins of ports D, E, F
   localparam logic [2:0][7:0] PORT_MASK = {8'hCF, 8'h1F, 8'h7F};

   localparam logic [7:0] PORT_DATA_RST = 8'hFF;
   localparam logic [7:0] PORT_CTRL_RST = 8'hFF;

   // 2-bit field codes
   localparam logic [1:0] FN_01 = 2'b01;
   localparam logic [1:0] FN_10 = 2'b10;
   localparam logic [1:0] FN_11 = 2'b11;

   // bit positions in the route registers
   localparam int RB_PT1 = 6;
   localparam int RB_PT0 = 5;
   localparam int RB_ST2 = 2;
   localparam int RB_ST1 = 1;
   localparam int RB_ST0 = 0;
   localparam int RB_SCS = 6;
   localparam int RB_SDI = 5;
   localparam int RB_SCK = 4;
   localparam int RB_U1  = 1;
   localparam int RB_U0  = 0;

   // bit-operation command fields
   localparam int BOP_BIT_LSB = 0;
   localparam int BOP_TGT_LSB = 3;
   localparam int BOP_VAL     = 8;

   // port numbers inside the synchroniser array
   localparam int PA = 0;
   localparam int PB = 1;
   localparam int PC = 2;
   localparam int PD = 3;
   localparam int PE = 4;
   localparam int PF = 5;

   typedef struct packed {
      logic [5:0][7:0] syncA;     // first stage
      logic [5:0][7:0] syncB;     // second stage
      logic [7:0]      paPrev;
      logic [9:0][7:0] sel;
      logic [2:0][7:0] pData;
      logic [2:0][7:0] pCtrl;
      logic [7:0]      wakeEn;
      logic            wrPend;
      logic            rdPend;
      logic [5:0]      aIdx;
      logic [31:0]     rdata;
      logic            hrdy;
      logic [2:0][7:0] pinOut;
      logic [2:0][7:0] pinOe;
      logic [4:0]      clkIn;     // st0 st1 st2 pt0 pt1
      logic [4:0]      capIn;
      logic [2:0]      serIn;     // cs data clock
      logic [3:0]      irqIn;
      logic [1:0]      rxIn;      // uart0 uart1
      logic            wake;
      logic            altSupply;
   } pfsel_state_t;
endpackage : pfsel_pkg
`default_nettype wire

/* File: design/pfsel_port_function_select.sv */
/*
 pfsel_port_function_select: function multiplexer for the pins of ports D, E, F,
 input-source routing for timer, serial, interrupt and uart inputs, port
 data/direction latches and port A wake-up, with an AHB-Lite register slave.
 Assumes all pins are asynchronous to clk and peripheral signals share clk.
*/
// Function
// - PD2 field: 01 periodic timer0 out, 10 uart1 transmit, else gpio.
// - PD1 field 10 routes pin to uart1 receive, else gpio.
// - PD0 field 10 drives standard timer1 output, else gpio.
// - PD6 field 10 drives standard timer2 output, else gpio.
// - PD5 field 10 drives uart0 transmit, else gpio.
// - PD4 field: 01 uart0 receive, 10 periodic timer1 out, else gpio.
// - PE3 at 11 is second spi clock, PE2 at 11 second spi data.
// - PE1: 10 standard timer0 out, 11 spi data; PE0 at 11 spi select.
// - PE4 at 11 becomes alternate io supply input, else gpio.
// - PF3/PF2: 10 serial clock/data, 11 lcd common 3/2, else gpio.
// - PF1/PF0: 10 serial data out/select, 11 lcd common 1/0.
// - PF7: 10 uart1 transmit, 11 standard timer2 out, else gpio.
// - PF6 at 11 connects uart1 receive, else gpio.
// - timer clock selector bit picks primary pin at 0, alternate at 1.
// - timer capture selector bit picks primary pin at 0, alternate at 1.
// - serial select, data, clock inputs pick port A at 0, port F at 1.
// - interrupt selectors pick port A pin at 0, alternate pin at 1.
// - uart receive selectors: uart1 PD1/PF6, uart0 PA6/PD4.
// - unimplemented selection bits ignore writes and read zero.
// - reset sets port data and direction bits high, pins start as inputs.
// - in sleep or idle, falling edge on enabled port A pin wakes.
// - single-bit set or clear reads whole port, modifies, writes back.
`timescale 1ns/1ps
`default_nettype none
module pfsel_port_function_select
   import pfsel_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic [7:0]  paIn,
   input  wire logic [7:0]  pbIn,
   input  wire logic [7:0]  pcIn,
   input  wire logic [7:0]  pdIn,
   output logic [7:0]       pdOut,
   output logic [7:0]       pdOe,
   input  wire logic [7:0]  peIn,
   output logic [7:0]       peOut,
   output logic [7:0]       peOe,
   input  wire logic [7:0]  pfIn,
   output logic [7:0]       pfOut,
   output logic [7:0]       pfOe,
   input  wire logic        periodicTimer0Output,
   input  wire logic        periodicTimer1Output,
   input  wire logic        standardTimer0Output,
   input  wire logic        standardTimer1Output,
   input  wire logic        standardTimer2Output,
   input  wire logic        uart0Transmit,
   input  wire logic        uart1Transmit,
   input  wire logic        secondSpiClock,
   input  wire logic        secondSpiDataOut,
   input  wire logic        secondSpiChipSelect,
   input  wire logic        serialClkOut,
   input  wire logic        serialClkOe,
   input  wire logic        serialDataOut,
   input  wire logic        serialDataOe,
   input  wire logic        serialSdo,
   input  wire logic        serialCsOut,
   input  wire logic [3:0]  lcdCommonLine,
   input  wire logic        sleepOrIdle,
   output logic             standardTimer0ClockIn,
   output logic             standardTimer1ClockIn,
   output logic             standardTimer2ClockIn,
   output logic             periodicTimer0ClockIn,
   output logic             periodicTimer1ClockIn,
   output logic             standardTimer0CaptureIn,
   output logic             standardTimer1CaptureIn,
   output logic             standardTimer2CaptureIn,
   output logic             periodicTimer0CaptureIn,
   output logic             periodicTimer1CaptureIn,
   output logic             serialCsIn,
   output logic             serialDataIn,
   output logic             serialClkIn,
   output logic [3:0]       externalIrqIn,
   output logic             uart0Receive,
   output logic             uart1Receive,
   output logic             wakeUp,
   output logic             alternateIoSupply
);
   import pfsel_pkg::*;

   pfsel_state_t s_q;
   pfsel_state_t s_d;

   // 2-bit selection field of pin pos inside a selection byte
   function automatic logic [1:0] fld(input logic [7:0] r, input logic [1:0] pos);
      fld = r[{pos, 1'b0} +: 2];
   endfunction : fld

   // pick primary pin at 0, alternate at 1
   function automatic logic pick(input logic s, input logic prim, input logic alt);
      pick = s ? alt : prim;
   endfunction : pick

   logic [5:0][7:0] pin;
   logic [7:0]      rmwBase;
   logic [7:0]      rmwNew;
   logic [2:0]      bopTgt;
   logic [2:0]      bopBit;
   logic [7:0]      falling;
   logic [2:0]      portSel;
   logic [3:0]      selSel;

   always_comb begin
      s_d     = s_q;
      pin     = s_q.syncB;   // only the second stage is read by logic
      rmwBase = 8'h00;
      rmwNew  = 8'h00;
      bopTgt  = hwdata[BOP_TGT_LSB +: 3];
      bopBit  = hwdata[BOP_BIT_LSB +: 3];
      portSel = 3'h0;
      selSel  = 4'h0;

      // two-flop synchronisers on every pin input
      s_d.syncA  = {pfIn, peIn, pdIn, pcIn, pbIn, paIn};
      s_d.syncB  = s_q.syncA;
      s_d.paPrev = pin[PA];

      // register writes, data phase
      if (s_q.wrPend) begin
         if (s_q.aIdx <= IDX_SEL_LAST) begin
            selSel = s_q.aIdx[3:0];
            s_d.sel[selSel] = hwdata[7:0] & SEL_MASK[selSel];
         end else if (s_q.aIdx <= IDX_DATA_LAST) begin
            portSel = 3'(s_q.aIdx - IDX_DATA_FIRST);
            s_d.pData[portSel] = hwdata[7:0] & PORT_MASK[portSel];
         end else if (s_q.aIdx <= IDX_CTRL_LAST) begin
            portSel = 3'(s_q.aIdx - IDX_CTRL_FIRST);
            s_d.pCtrl[portSel] = (hwdata[7:0] & PORT_MASK[portSel]) | ~PORT_MASK[portSel];
         end else if (s_q.aIdx == IDX_WAKE_EN) begin
            s_d.wakeEn = hwdata[7:0];
         end else if (s_q.aIdx == IDX_BIT_OP) begin
            // data targets read the pins, so an input pin's level lands in its latch
            if (bopTgt < 3'd3) begin
               rmwBase = pin[PD + 32'(bopTgt)] & PORT_MASK[bopTgt[1:0]];
            end else if (bopTgt < 3'd6) begin
               rmwBase = s_q.pCtrl[bopTgt - 3'd3];
            end
            rmwNew = rmwBase;
            rmwNew[bopBit] = hwdata[BOP_VAL];
            if (bopTgt < 3'd3) begin
               s_d.pData[bopTgt] = rmwNew & PORT_MASK[bopTgt[1:0]];
            end else if (bopTgt < 3'd6) begin
               s_d.pCtrl[bopTgt - 3'd3] = rmwNew | ~PORT_MASK[bopTgt - 3'd3];
            end
         end
      end

      // bus: writes zero-wait, reads take one wait state
      s_d.hrdy = 1'b1;
      if (s_q.rdPend) begin
         s_d.rdPend = 1'b0;
         s_d.rdata  = 32'h0000_0000;
         if (s_q.aIdx <= IDX_SEL_LAST) begin
            s_d.rdata[7:0] = s_q.sel[s_q.aIdx[3:0]];
         end else if (s_q.aIdx <= IDX_DATA_LAST) begin
            portSel = 3'(s_q.aIdx - IDX_DATA_FIRST);
            s_d.rdata[7:0] = pin[PD + 32'(portSel)] & PORT_MASK[portSel];
         end else if (s_q.aIdx <= IDX_CTRL_LAST) begin
            portSel = 3'(s_q.aIdx - IDX_CTRL_FIRST);
            s_d.rdata[7:0] = s_q.pCtrl[portSel] & PORT_MASK[portSel];
         end else if (s_q.aIdx == IDX_WAKE_EN) begin
            s_d.rdata[7:0] = s_q.wakeEn;
         end else if (s_q.aIdx == IDX_PORTA_PINS) begin
            s_d.rdata[7:0] = pin[PA];
         end
      end else if (hready) begin
         s_d.wrPend = hsel & htrans[1] & hwrite;
         s_d.rdPend = hsel & htrans[1] & ~hwrite;
         s_d.aIdx   = haddr[7:2];
         if (hsel & htrans[1] & ~hwrite) begin
            s_d.hrdy = 1'b0;
         end
      end

      // gpio default: drive latch where direction bit is low
      for (int k = 0; k < 3; k++) begin
         s_d.pinOut[k] = s_q.pData[k];
         s_d.pinOe[k]  = ~s_q.pCtrl[k] & PORT_MASK[k];
      end

      // port D
      if (fld(s_q.sel[SEL_D_LOW], 2'd0) == FN_10) begin
         s_d.pinOut[0][0] = standardTimer1Output;
         s_d.pinOe[0][0]  = 1'b1;
      end
      if (fld(s_q.sel[SEL_D_LOW], 2'd1) == FN_10) begin
         s_d.pinOe[0][1] = 1'b0;
      end
      case (fld(s_q.sel[SEL_D_LOW], 2'd2))
         FN_01: begin
            s_d.pinOut[0][2] = periodicTimer0Output;
            s_d.pinOe[0][2]  = 1'b1;
         end
         FN_10: begin
            s_d.pinOut[0][2] = uart1Transmit;
            s_d.pinOe[0][2]  = 1'b1;
         end
         default: begin
         end
      endcase
      case (fld(s_q.sel[SEL_D_HIGH], 2'd0))
         FN_01: begin
            s_d.pinOe[0][4] = 1'b0;
         end
         FN_10: begin
            s_d.pinOut[0][4] = periodicTimer1Output;
            s_d.pinOe[0][4]  = 1'b1;
         end
         default: begin
         end
      endcase
      if (fld(s_q.sel[SEL_D_HIGH], 2'd1) == FN_10) begin
         s_d.pinOut[0][5] = uart0Transmit;
         s_d.pinOe[0][5]  = 1'b1;
      end
      if (fld(s_q.sel[SEL_D_HIGH], 2'd2) == FN_10) begin
         s_d.pinOut[0][6] = standardTimer2Output;
         s_d.pinOe[0][6]  = 1'b1;
      end

      // port E
      if (fld(s_q.sel[SEL_E_LOW], 2'd0) == FN_11) begin
         s_d.pinOut[1][0] = secondSpiChipSelect;
         s_d.pinOe[1][0]  = 1'b1;
      end
      case (fld(s_q.sel[SEL_E_LOW], 2'd1))
         FN_10: begin
            s_d.pinOut[1][1] = standardTimer0Output;
            s_d.pinOe[1][1]  = 1'b1;
         end
         FN_11: begin
            s_d.pinOut[1][1] = secondSpiDataOut;
            s_d.pinOe[1][1]  = 1'b1;
         end
         default: begin
         end
      endcase
      if (fld(s_q.sel[SEL_E_LOW], 2'd2) == FN_11) begin
         s_d.pinOut[1][2] = secondSpiDataOut;
         s_d.pinOe[1][2]  = 1'b1;
      end
      if (fld(s_q.sel[SEL_E_LOW], 2'd3) == FN_11) begin
         s_d.pinOut[1][3] = secondSpiClock;
         s_d.pinOe[1][3]  = 1'b1;
      end
      // supply pin must never be driven by the port
      s_d.altSupply = (fld(s_q.sel[SEL_E_HIGH], 2'd0) == FN_11);
      if (s_d.altSupply) begin
         s_d.pinOut[1][4] = 1'b0;
         s_d.pinOe[1][4]  = 1'b0;
      end

      // port F, low four pins
      for (int k = 0; k < 4; k++) begin
         case (fld(s_q.sel[SEL_F_LOW], 2'(k)))
            FN_10: begin
               case (k)
                  0: begin
                     s_d.pinOut[2][0] = serialCsOut;
                     s_d.pinOe[2][0]  = 1'b1;
                  end
                  1: begin
                     s_d.pinOut[2][1] = serialSdo;
                     s_d.pinOe[2][1]  = 1'b1;
                  end
                  2: begin
                     s_d.pinOut[2][2] = serialDataOut;
                     s_d.pinOe[2][2]  = serialDataOe;
                  end
                  default: begin
                     s_d.pinOut[2][3] = serialClkOut;
                     s_d.pinOe[2][3]  = serialClkOe;
                  end
               endcase
            end
            FN_11: begin
               s_d.pinOut[2][k] = lcdCommonLine[k];
               s_d.pinOe[2][k]  = 1'b1;
            end
            default: begin
            end
         endcase
      end
      if (fld(s_q.sel[SEL_F_HIGH], 2'd2) == FN_11) begin
         s_d.pinOe[2][6] = 1'b0;
      end
      case (fld(s_q.sel[SEL_F_HIGH], 2'd3))
         FN_10: begin
            s_d.pinOut[2][7] = uart1Transmit;
            s_d.pinOe[2][7]  = 1'b1;
         end
         FN_11: begin
            s_d.pinOut[2][7] = standardTimer2Output;
            s_d.pinOe[2][7]  = 1'b1;
         end
         default: begin
         end
      endcase

      // input routing; pin functions are input-only so the pin level is shared
      s_d.clkIn[0] = pick(s_q.sel[ROUTE_CLK][RB_ST0], pin[PC][7], pin[PE][0]);
      s_d.clkIn[1] = pick(s_q.sel[ROUTE_CLK][RB_ST1], pin[PD][1], pin[PB][7]);
      s_d.clkIn[2] = pick(s_q.sel[ROUTE_CLK][RB_ST2], pin[PF][6], pin[PB][0]);
      s_d.clkIn[3] = pick(s_q.sel[ROUTE_CLK][RB_PT0], pin[PD][3], pin[PB][2]);
      s_d.clkIn[4] = pick(s_q.sel[ROUTE_CLK][RB_PT1], pin[PD][5], pin[PB][1]);
      s_d.capIn[0] = pick(s_q.sel[ROUTE_CAP][RB_ST0], pin[PC][6], pin[PE][1]);
      s_d.capIn[1] = pick(s_q.sel[ROUTE_CAP][RB_ST1], pin[PD][0], pin[PB][6]);
      s_d.capIn[2] = pick(s_q.sel[ROUTE_CAP][RB_ST2], pin[PD][6], pin[PF][7]);
      s_d.capIn[3] = pick(s_q.sel[ROUTE_CAP][RB_PT0], pin[PD][2], pin[PB][3]);
      s_d.capIn[4] = pick(s_q.sel[ROUTE_CAP][RB_PT1], pin[PD][4], pin[PB][2]);
      s_d.serIn[0] = pick(s_q.sel[ROUTE_SER][RB_SCS], pin[PA][1], pin[PF][0]);
      s_d.serIn[1] = pick(s_q.sel[ROUTE_SER][RB_SDI], pin[PA][4], pin[PF][2]);
      s_d.serIn[2] = pick(s_q.sel[ROUTE_SER][RB_SCK], pin[PA][5], pin[PF][3]);
      s_d.irqIn[0] = pick(s_q.sel[ROUTE_SER][0], pin[PA][1], pin[PA][6]);
      s_d.irqIn[1] = pick(s_q.sel[ROUTE_SER][1], pin[PA][3], pin[PA][7]);
      s_d.irqIn[2] = pick(s_q.sel[ROUTE_SER][2], pin[PA][4], pin[PD][0]);
      s_d.irqIn[3] = pick(s_q.sel[ROUTE_SER][3], pin[PA][5], pin[PC][7]);
      s_d.rxIn[0]  = pick(s_q.sel[ROUTE_RX][RB_U0], pin[PA][6], pin[PD][4]);
      s_d.rxIn[1]  = pick(s_q.sel[ROUTE_RX][RB_U1], pin[PD][1], pin[PF][6]);

      // wake pulse on an enabled port A falling edge
      falling  = s_q.paPrev & ~pin[PA] & s_q.wakeEn;
      s_d.wake = sleepOrIdle & (|falling);
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_q       <= '0;
         s_q.pData <= {3{PORT_DATA_RST}};
         s_q.pCtrl <= {3{PORT_CTRL_RST}};
         s_q.hrdy  <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign hreadyout = s_q.hrdy;
   assign hresp     = 1'b0;
   assign hrdata    = s_q.rdata;
   assign pdOut     = s_q.pinOut[0];
   assign pdOe      = s_q.pinOe[0];
   assign peOut     = s_q.pinOut[1];
   assign peOe      = s_q.pinOe[1];
   assign pfOut     = s_q.pinOut[2];
   assign pfOe      = s_q.pinOe[2];

   assign standardTimer0ClockIn   = s_q.clkIn[0];
   assign standardTimer1ClockIn   = s_q.clkIn[1];
   assign standardTimer2ClockIn   = s_q.clkIn[2];
   assign periodicTimer0ClockIn   = s_q.clkIn[3];
   assign periodicTimer1ClockIn   = s_q.clkIn[4];
   assign standardTimer0CaptureIn = s_q.capIn[0];
   assign standardTimer1CaptureIn = s_q.capIn[1];
   assign standardTimer2CaptureIn = s_q.capIn[2];
   assign periodicTimer0CaptureIn = s_q.capIn[3];
   assign periodicTimer1CaptureIn = s_q.capIn[4];
   assign serialCsIn              = s_q.serIn[0];
   assign serialDataIn            = s_q.serIn[1];
   assign serialClkIn             = s_q.serIn[2];
   assign externalIrqIn           = s_q.irqIn;
   assign uart0Receive            = s_q.rxIn[0];
   assign uart1Receive            = s_q.rxIn[1];
   assign wakeUp                  = s_q.wake;
   assign alternateIoSupply       = s_q.altSupply;

   // hsize unused: only whole-word transfers are supported
   logic unusedBits;
   assign unusedBits = ^{hsize, haddr[31:8], haddr[1:0]};
endmodule : pfsel_port_function_select
`default_nettype wire

/* File: dv/pfsel_asserts.sv */
/* pfsel_asserts: bus, pin enable and wake checks on the top ports.
   Assumes hready is the slave's own hreadyout. */
`timescale 1ns/1ps
`default_nettype none
module pfsel_asserts (
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic [7:0]  pdOe,
   input wire logic [7:0]  peOe,
   input wire logic [7:0]  pfOe,
   input wire logic        sleepOrIdle,
   input wire logic        wakeUp,
   input wire logic        alternateIoSupply
);
   logic rdTake;
   logic wrTake;
   assign rdTake = hsel & htrans[1] & hready & ~hwrite;
   assign wrTake = hsel & htrans[1] & hready & hwrite;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_resp_okay: assert property (hresp == 1'b0) else $error("bus response not okay");
   a_read_wait: assert property (rdTake |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
   a_write_nowait: assert property (wrTake |=> hreadyout) else $error("write stalled");
   a_rdata_upper: assert property (hrdata[31:8] == 24'h0) else $error("read data upper set");
   // read data holds until next read
   a_rdata_stands: assert property (!$past(rdTake, 2) |-> $stable(hrdata)) else $error("read data moved");
   a_reset_oe: assert property ($fell(sys_rst) |-> (pdOe | peOe | pfOe) == 8'h0) else $error("pin driven at reset");
   a_wake_pulse: assert property (wakeUp |=> !wakeUp) else $error("wake pulse too long");
   a_wake_asleep: assert property (wakeUp |-> $past(sleepOrIdle)) else $error("wake while awake");
   a_supply_input: assert property (alternateIoSupply && $past(alternateIoSupply) |-> !peOe[4])
      else $error("supply pin driven");
   c_read: cover property (rdTake);
   c_wake: cover property (wakeUp);
   c_supply: cover property (alternateIoSupply);
endmodule : pfsel_asserts
bind pfsel_port_function_select pfsel_asserts pfsel_asserts_inst (.*);
`default_nettype wire

/* File: dv/pfsel_pin_partner.sv */
/* pfsel_pin_partner: far side of the port D, E and F pins.
   Assumes the bench gives the outside level of every pin. */
`timescale 1ns/1ps
`default_nettype none
module pfsel_pin_partner (
   input wire logic [7:0] pdOut,
   input wire logic [7:0] pdOe,
   input wire logic [7:0] peOut,
   input wire logic [7:0] peOe,
   input wire logic [7:0] pfOut,
   input wire logic [7:0] pfOe,
   input wire logic [7:0] pdExt,
   input wire logic [7:0] peExt,
   input wire logic [7:0] pfExt,
   output logic [7:0]     pdIn,
   output logic [7:0]     peIn,
   output logic [7:0]     pfIn
);
   // a driven pin reads back its own drive, else the outside level
   assign pdIn = (pdOut & pdOe) | (pdExt & ~pdOe);
   assign peIn = (peOut & peOe) | (peExt & ~peOe);
   assign pfIn = (pfOut & pfOe) | (pfExt & ~pfOe);
endmodule : pfsel_pin_partner
`default_nettype wire

/* File: dv/test_port_function_select.sv */
/* test_port_function_select: self-checking bench with a register model.
   Assumes the pin partner resolves ports D, E and F. */
`timescale 1ns/1ps
`default_nettype none
module test_port_function_select;
   import pfsel_pkg::*;
   logic clk, sys_rst, hsel, hwrite, hreadyout, hresp, sleepOrIdle, wakeUp, alternateIoSupply;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [5:0] idx;
   logic [31:0] haddr, hwdata, hrdata, q, cnt;
   logic [7:0] paIn, pbIn, pcIn, pdIn, peIn, pfIn, pdOut, peOut, pfOut, pdOe, peOe, pfOe, pdExt, peExt, pfExt;
   logic [19:0] periph;
   logic [3:0] lcdCommonLine, externalIrqIn;
   logic periodicTimer0Output, periodicTimer1Output, standardTimer0Output, standardTimer1Output;
   logic standardTimer2Output, uart0Transmit, uart1Transmit, secondSpiClock, secondSpiDataOut;
   logic secondSpiChipSelect, serialClkOut, serialClkOe, serialDataOut, serialDataOe, serialSdo, serialCsOut;
   logic standardTimer0ClockIn, standardTimer1ClockIn, standardTimer2ClockIn, periodicTimer0ClockIn;
   logic periodicTimer1ClockIn, standardTimer0CaptureIn, standardTimer1CaptureIn, standardTimer2CaptureIn;
   logic periodicTimer0CaptureIn, periodicTimer1CaptureIn, serialCsIn, serialDataIn, serialClkIn;
   logic uart0Receive, uart1Receive;
   logic [7:0] regModel [0:31];
   logic [7:0] fnCodes [0:5] = '{8'h1A, 8'h2A, 8'hFB, 8'h03, 8'hFA, 8'hB0};
   int miscompares, totalChecks, cycles;
   assign {periodicTimer0Output, periodicTimer1Output, standardTimer0Output, standardTimer1Output,
           standardTimer2Output, uart0Transmit, uart1Transmit, secondSpiClock, secondSpiDataOut,
           secondSpiChipSelect, serialClkOut, serialClkOe, serialDataOut, serialDataOe, serialSdo,
           serialCsOut, lcdCommonLine} = periph;
   pfsel_port_function_select pfsel_port_function_select_inst (.hready(hreadyout), .*);
   pfsel_pin_partner pfsel_pin_partner_inst (.*);
   always #2.5 clk = ~clk;
   task automatic finish_test;
      $display("checks %0d mismatches %0d", totalChecks, miscompares);
      if (miscompares == 0 && totalChecks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : finish_test
   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 8000) begin
         miscompares++;
         finish_test();
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic busCycle(input logic [5:0] a, input logic wr, input logic [31:0] d, output logic [31:0] r);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a, 2'h0};
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      r = hrdata;
      if (wr && a <= IDX_SEL_LAST) regModel[a] = d[7:0] & SEL_MASK[a];
   endtask : busCycle
   task automatic wakeCount(input logic [7:0] pa, input logic [31:0] exp);
      paIn <= pa;
      cnt = 32'h0;
      repeat (6) begin
         @(posedge clk);
         cnt = cnt + wakeUp;
      end
      check("wake pulses", cnt, exp);
   endtask : wakeCount
   initial begin
      {hsel, hwrite, sleepOrIdle, htrans, haddr, hwdata, paIn, pbIn, pcIn, pdExt, peExt, pfExt, periph} = '0;
      {clk, hsize, sys_rst} = 5'h5;
      foreach (regModel[i]) regModel[i] = 8'h00;
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      void'($urandom(32'h1FE2));
      for (int i = 0; i < 13; i++) begin
         idx = (i < 10) ? i[5:0] : IDX_CTRL_FIRST + i[5:0] - 6'hA;
         busCycle(idx, 1'b0, 32'h0, q);
         check("reset value", q, (i < 10) ? {24'h0, regModel[idx]} : {24'h0, PORT_MASK[i - 10]});
      end
      for (int s = 0; s < 2; s++) begin
         for (int i = ROUTE_CLK; i <= ROUTE_RX; i++) busCycle(i[5:0], 1'b1, s ? 32'hFF : 32'h0, q);
         {paIn, pbIn, pcIn, pdExt} <= $urandom;
         {peExt, pfExt} <= 16'($urandom);
         repeat (5) @(posedge clk);
         check("ptimer1 clock", periodicTimer1ClockIn, s ? pbIn[1] : pdExt[5]);
         check("stimer0 clock", standardTimer0ClockIn, s ? peExt[0] : pcIn[7]);
         check("ptimer1 capture", periodicTimer1CaptureIn, s ? pbIn[2] : pdExt[4]);
         check("stimer2 capture", standardTimer2CaptureIn, s ? pfExt[7] : pdExt[6]);
         check("serial select in", serialCsIn, s ? pfExt[0] : paIn[1]);
         check("irq two", externalIrqIn[2], s ? pdExt[0] : paIn[4]);
         check("uart1 receive", uart1Receive, s ? pfExt[6] : pdExt[1]);
         check("uart0 receive", uart0Receive, s ? pdExt[4] : paIn[6]);
         check("routes", {serialDataIn, serialClkIn, externalIrqIn}, s ? {pfExt[2], pfExt[3], pcIn[7], pdExt[0],
               paIn[7:6]} : {paIn[4], paIn[5], paIn[5:3], paIn[1]});
      end
      // random fill, one unmapped word
      for (int i = 0; i < 11; i++) begin
         idx = (i == 10) ? 6'h13 : i[5:0];
         busCycle(idx, 1'b1, {24'h0, 8'($urandom)}, q);
         busCycle(idx, 1'b0, 32'h0, q);
         check("readback", q, {24'h0, regModel[idx]});
      end
      busCycle(IDX_SEL_FIRST, 1'b1, 32'h0, q);
      busCycle(IDX_SEL_FIRST + 6'h1, 1'b1, 32'h0, q);
      pdExt <= 8'h00;
      busCycle(IDX_CTRL_FIRST, 1'b1, 32'h1, q);
      repeat (3) @(posedge clk);
      check("gpio drive", {pdOe[6:1], pdOut[6:1]}, 32'hFFF);
      // clear bit 3 of port D data; input pin 0 low is copied in
      busCycle(IDX_BIT_OP, 1'b1, 32'h3, q);
      busCycle(IDX_CTRL_FIRST, 1'b1, 32'h0, q);
      repeat (3) @(posedge clk);
      check("bit clear", pdOut & 8'h7F, 32'h76);
      busCycle(IDX_CTRL_FIRST + 6'h1, 1'b1, 32'h0, q);
      busCycle(IDX_CTRL_FIRST + 6'h2, 1'b1, 32'h0, q);
      for (int i = 0; i < 6; i++) busCycle(i[5:0], 1'b1, {24'h0, fnCodes[i]}, q);
      repeat (2) begin
         periph <= 20'($urandom);
         repeat (3) @(posedge clk);
         check("port D", {pdOut[6:4], pdOut[2], pdOut[0], pdOe[1]}, {standardTimer2Output, uart0Transmit,
               periodicTimer1Output, periodicTimer0Output, standardTimer1Output, 1'b0});
         check("port E", {peOut[3:0], peOe[4], alternateIoSupply}, {secondSpiClock, secondSpiDataOut,
               standardTimer0Output, secondSpiChipSelect, 2'h1});
         check("port F", {pfOut[7], pfOe[6], pfOut[3:0]}, {uart1Transmit, 1'b0, lcdCommonLine[3:2],
               serialSdo, serialCsOut});
      end
      busCycle(IDX_WAKE_EN, 1'b1, 32'h1, q);
      sleepOrIdle <= 1'b1;
      paIn <= 8'hFF;
      repeat (6) @(posedge clk);
      wakeCount(8'hFD, 32'h0);
      wakeCount(8'hFC, 32'h1);
      finish_test();
   end
endmodule : test_port_function_select
`default_nettype wire
